//--- core/ufl_core.sv
`timescale 1ns/10ps
// Summary of operation
// - Read-only TX FIFO level, 0x00 to 0x40, equals characters held.
// - Write-only TX threshold, 0x00 to 0x40, is stored.
// - TX interrupt while TX level is below TX threshold.
// - Read-only RX FIFO level, 0x00 to 0x40, equals characters waiting.
// - Write-only RX threshold, 0x00 to 0x40, is stored.
// - RX interrupt once RX level reaches RX threshold.
// - In reset TX idles high, or low when infrared select is high.
// - After reset modem status low nibble zero, high nibble shows pins.
// - Per-channel data-plus-status window, channel 0 at 0x180.
// - Identification register at 0x8D byte, 0x8C doubleword.
// - Identification register read-only; a write sets the armed flag and restarts window reads at a data byte.
// - Window reads return ordered data then status bytes, armed or not.
// - Global interrupt at 0x080, channel maps at 0x081 to 0x083.
module ufl_core (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic [11:0] REG_ADDR,
   input wire logic REG_DWORD,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [7:0] TX_PUSH,
   input wire logic [7:0] TX_POP,
   input wire logic [7:0] RX_PUSH,
   input wire logic [7:0] RX_POP,
   input wire logic [7:0] RX_PAIR_VALID,
   input wire logic [63:0] RX_PAIR_CHAR,
   input wire logic [63:0] RX_PAIR_STAT,
   output logic [7:0] RX_PAIR_READY,
   output logic [7:0] TX_INT,
   output logic [7:0] RX_INT,
   input wire logic [31:0] MODEM_IN,
   input wire logic INFRARED_MODE_SELECT_PIN,
   input wire logic [7:0] TX_SER,
   output logic [7:0] TX_OUT,
   input wire logic [7:0] RTS_REQ,
   input wire logic [7:0] DTR_REQ,
   output logic [7:0] RTS_B,
   output logic [7:0] DTR_B,
   input wire logic EE_CLK_REQ,
   input wire logic EE_SEL_REQ,
   input wire logic EE_DIN_REQ,
   output logic SERIAL_EEPROM_CLOCK,
   output logic SERIAL_EEPROM_SELECT,
   output logic SERIAL_EEPROM_DATA_IN
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0][7:0] tx_level;
      logic [7:0][7:0] tx_thr;
      logic [7:0][7:0] rx_level;
      logic [7:0][7:0] rx_thr;
      logic [7:0][3:0] modem_last;
      logic [7:0][3:0] modem_delta;
      logic [2:0] warm;
      logic armed;
      logic phase;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] tx_int;
      logic [7:0] rx_int;
      logic [7:0] tx_space;
      logic [7:0] rts_b;
      logic [7:0] dtr_b;
      logic ee_clk;
      logic ee_sel;
      logic ee_din;
   } ufl_core_state_type;

   ufl_core_state_type q, d;

   logic [31:0] modem_s;
   logic ir_s;
   logic [7:0] stage_valid;
   logic [7:0] stage_pop;
   logic [7:0][15:0] stage_data;
   logic [2:0] chan;
   logic [8:0] offset;
   logic hit_dev_id;
   logic hit_window;
   logic [23:0] chan_map;

   // ------------------------------------------------------------------
   // Pin synchronisers and receive staging buffers
   // ------------------------------------------------------------------
   ufl_sync #(.WIDTH(33)) u_sync (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .din({INFRARED_MODE_SELECT_PIN, MODEM_IN}),
      .dout({ir_s, modem_s})
   );

   // Each buffer stalls the channel's receive path through RX_PAIR_READY.
   for (genvar c = 0; c < ufl_pkg::NUM_CH; c++) begin : g_stage
      ufl_fifo #(
         .WIDTH(ufl_pkg::STAGE_WIDTH),
         .DEPTH(ufl_pkg::STAGE_DEPTH)
      ) u_stage (
         .clk(SYS_CLK),
         .rst_b(RST_B),
         .in_valid(RX_PAIR_VALID[c]),
         .in_ready(RX_PAIR_READY[c]),
         .in_data({RX_PAIR_CHAR[c*8 +: 8], RX_PAIR_STAT[c*8 +: 8]}),
         .out_valid(stage_valid[c]),
         .out_ready(stage_pop[c]),
         .out_data(stage_data[c])
      );
   end

   // ------------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------------
   always_comb begin
      chan = REG_ADDR[11:9];
      offset = REG_ADDR[8:0];
      hit_window = (offset == ufl_pkg::RX_WINDOW_OFF);
      hit_dev_id = REG_DWORD ? (REG_ADDR == ufl_pkg::DEV_ID_DWORD_ADDR)
                             : (REG_ADDR == ufl_pkg::DEV_ID_BYTE_ADDR);
      for (int c = 0; c < ufl_pkg::NUM_CH; c++) begin
         if (q.rx_int[c]) begin
            chan_map[c*3 +: 3] = ufl_pkg::CODE_RX;
         end else if (q.tx_int[c]) begin
            chan_map[c*3 +: 3] = ufl_pkg::CODE_TX;
         end else begin
            chan_map[c*3 +: 3] = ufl_pkg::CODE_NONE;
         end
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      d.rvalid = 1'b0;
      stage_pop = '0;

      // Line outputs follow their requests; reset values are the idle ones.
      d.rts_b = ~RTS_REQ;
      d.dtr_b = ~DTR_REQ;
      d.ee_clk = EE_CLK_REQ;
      d.ee_sel = EE_SEL_REQ;
      d.ee_din = EE_DIN_REQ;
      // The register holds the inverse of the mark level; see TX_OUT.
      d.tx_space = TX_SER ^ {8{~ir_s}};

      if (q.warm != ufl_pkg::WARM_DONE) begin
         d.warm = q.warm + 3'h1;
      end

      for (int c = 0; c < ufl_pkg::NUM_CH; c++) begin
         // Saturating level counters.
         if (TX_PUSH[c] && !TX_POP[c] &&
             q.tx_level[c] < ufl_pkg::FIFO_FULL_LEVEL) begin
            d.tx_level[c] = q.tx_level[c] + 8'h01;
         end else if (TX_POP[c] && !TX_PUSH[c] &&
                      q.tx_level[c] != 8'h00) begin
            d.tx_level[c] = q.tx_level[c] - 8'h01;
         end
         if (RX_PUSH[c] && !RX_POP[c] &&
             q.rx_level[c] < ufl_pkg::FIFO_FULL_LEVEL) begin
            d.rx_level[c] = q.rx_level[c] + 8'h01;
         end else if (RX_POP[c] && !RX_PUSH[c] &&
                      q.rx_level[c] != 8'h00) begin
            d.rx_level[c] = q.rx_level[c] - 8'h01;
         end
         d.tx_int[c] = d.tx_level[c] < q.tx_thr[c];
         d.rx_int[c] = d.rx_level[c] >= q.rx_thr[c];
         d.modem_last[c] = modem_s[c*4 +: 4];
      end

      // Register read.
      if (REG_RD) begin
         d.rvalid = 1'b1;
         d.rdata = 8'h00;
         if (REG_ADDR == ufl_pkg::GLOBAL_INT_ADDR) begin
            d.rdata = q.tx_int | q.rx_int;
         end else if (REG_ADDR == ufl_pkg::CHAN_MAP_FIRST_ADDR) begin
            d.rdata = chan_map[7:0];
         end else if (REG_ADDR == ufl_pkg::CHAN_MAP_MID_ADDR) begin
            d.rdata = chan_map[15:8];
         end else if (REG_ADDR == ufl_pkg::CHAN_MAP_LAST_ADDR) begin
            d.rdata = chan_map[23:16];
         end else if (hit_dev_id) begin
            d.rdata = ufl_pkg::DEVICE_ID_VALUE;
         end else if (offset == ufl_pkg::TX_LEVEL_OFF) begin
            d.rdata = q.tx_level[chan];
         end else if (offset == ufl_pkg::RX_LEVEL_OFF) begin
            d.rdata = q.rx_level[chan];
         end else if (offset == ufl_pkg::MODEM_STATUS_OFF) begin
            d.rdata = {modem_s[chan*4 +: 4], q.modem_delta[chan]};
            d.modem_delta[chan] = 4'h0;
         end else if (hit_window) begin
            // Data first, then its status; the status read retires the pair.
            if (!stage_valid[chan]) begin
               d.rdata = 8'h00;
            end else if (!q.phase) begin
               d.rdata = stage_data[chan][15:8];
            end else begin
               d.rdata = stage_data[chan][7:0];
               stage_pop[chan] = 1'b1;
            end
            d.phase = ~q.phase;
         end
      end

      // Register write; read-only locations ignore the data.
      if (REG_WR) begin
         if (hit_dev_id) begin
            d.armed = 1'b1;
            d.phase = 1'b0;
         end else if (REG_ADDR[11:8] != 4'h0 || offset < 9'h080) begin
            if (offset == ufl_pkg::TX_LEVEL_OFF) begin
               d.tx_thr[chan] = REG_WDATA;
            end else if (offset == ufl_pkg::RX_LEVEL_OFF) begin
               d.rx_thr[chan] = REG_WDATA;
            end
         end
      end

      // Any access other than to the identification register or a window read clears the armed flag until the next arming write.
      if ((REG_RD || REG_WR) && !hit_dev_id &&
          !(REG_RD && hit_window)) begin
         d.armed = 1'b0;
      end

      // Deltas set after the synchronisers settle; set beats a read clear.
      if (q.warm == ufl_pkg::WARM_DONE) begin
         for (int c = 0; c < ufl_pkg::NUM_CH; c++) begin
            d.modem_delta[c] = d.modem_delta[c] |
               (modem_s[c*4 +: 4] ^ q.modem_last[c]);
         end
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         q <= '0;
         for (int c = 0; c < ufl_pkg::NUM_CH; c++) begin
            q.tx_level[c] <= ufl_pkg::LEVEL_RESET;
            q.rx_level[c] <= ufl_pkg::LEVEL_RESET;
            q.tx_thr[c] <= ufl_pkg::THRESHOLD_RESET;
            q.rx_thr[c] <= ufl_pkg::THRESHOLD_RESET;
         end
         q.rts_b <= 8'hff;
         q.dtr_b <= 8'hff;
         q.ee_clk <= 1'b0;
         q.ee_sel <= 1'b0;
         q.ee_din <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign REG_RDATA = q.rdata;
   assign REG_RVALID = q.rvalid;
   assign TX_INT = q.tx_int;
   assign RX_INT = q.rx_int;
   assign RTS_B = q.rts_b;
   assign DTR_B = q.dtr_b;
   assign SERIAL_EEPROM_CLOCK = q.ee_clk;
   assign SERIAL_EEPROM_SELECT = q.ee_sel;
   assign SERIAL_EEPROM_DATA_IN = q.ee_din;
   // The idle level must follow the strap even while reset holds the
   // register, so the raw strap pin sets the final polarity.
   assign TX_OUT = q.tx_space ^ {8{~INFRARED_MODE_SELECT_PIN}};
endmodule

//--- inc/ufl_pkg.sv
package ufl_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int NUM_CH = 8;
   localparam logic [7:0] FIFO_FULL_LEVEL = 8'h40;
   localparam int STAGE_WIDTH = 16;
   localparam int STAGE_DEPTH = 8;
   // Deltas wait until the synchronised pins and their last copy agree.
   localparam logic [2:0] WARM_DONE = 3'h5;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [11:0] GLOBAL_INT_ADDR = 12'h080;
   localparam logic [11:0] CHAN_MAP_FIRST_ADDR = 12'h081;
   localparam logic [11:0] CHAN_MAP_MID_ADDR = 12'h082;
   localparam logic [11:0] CHAN_MAP_LAST_ADDR = 12'h083;
   localparam logic [11:0] DEV_ID_BYTE_ADDR = 12'h08d;
   localparam logic [11:0] DEV_ID_DWORD_ADDR = 12'h08c;
   // Offsets inside each channel's 512-byte block.
   localparam logic [8:0] MODEM_STATUS_OFF = 9'h006;
   localparam logic [8:0] TX_LEVEL_OFF = 9'h00a;
   localparam logic [8:0] RX_LEVEL_OFF = 9'h00b;
   localparam logic [8:0] RX_WINDOW_OFF = 9'h180;
   // Arbitrary identification value.
   localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;

   // -------------------------------------------------------------
   // Reset values and interrupt codes
   // -------------------------------------------------------------
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_RX = 3'h1;
   localparam logic [2:0] CODE_TX = 3'h2;
endpackage

//--- core/ufl_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; the output follows once stages two and three
// agree, which filters a single-cycle glitch.
module ufl_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } ufl_sync_state_type;

   ufl_sync_state_type q, d;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.out[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.out;
endmodule

//--- core/ufl_fifo.sv
`timescale 1ns/10ps
// Small show-ahead FIFO; the head word is held in a register.
module ufl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic full;
      logic empty;
      logic [WIDTH-1:0] head;
   } ufl_fifo_state_type;

   ufl_fifo_state_type q, d;
   logic push;
   logic pop;

   always_comb begin
      d = q;
      push = in_valid && !q.full;
      pop = out_ready && !q.empty;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
      d.full = (d.count == (AW + 1)'(DEPTH));
      d.empty = (d.count == '0);
      d.head = d.mem[d.rd];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.empty <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready = !q.full;
   assign out_valid = !q.empty;
   assign out_data = q.head;
endmodule

//--- dv/ufl_core_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Port-level checks of the register read, interrupt and reset logic
// ----------------------------------------------------------
module ufl_core_props (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic [11:0] REG_ADDR,
   input wire logic REG_DWORD,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic [7:0] TX_PUSH,
   input wire logic [7:0] RX_PUSH,
   input wire logic [7:0] RX_PAIR_READY,
   input wire logic [7:0] TX_INT,
   input wire logic [7:0] RX_INT,
   input wire logic INFRARED_MODE_SELECT_PIN,
   input wire logic [7:0] TX_OUT,
   input wire logic [7:0] RTS_B,
   input wire logic [7:0] DTR_B,
   input wire logic SERIAL_EEPROM_CLOCK,
   input wire logic SERIAL_EEPROM_SELECT,
   input wire logic SERIAL_EEPROM_DATA_IN
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);
   chk_read_answer: assert property (
      REG_RVALID == $past(REG_RD)) else $error("read answer timing");
   chk_id_value: assert property (
      REG_RD && !REG_DWORD && REG_ADDR == ufl_pkg::DEV_ID_BYTE_ADDR
      |=> REG_RDATA == ufl_pkg::DEVICE_ID_VALUE) else $error("id value");
   chk_global_int: assert property (
      REG_RD && REG_ADDR == ufl_pkg::GLOBAL_INT_ADDR
      |=> REG_RDATA == ($past(TX_INT) | $past(RX_INT)))
      else $error("global interrupt value");
   chk_modem_ctl_idle: assert property (
      $rose(RST_B) |-> RTS_B == 8'hff && DTR_B == 8'hff)
      else $error("modem control idle level");
   chk_eeprom_idle: assert property (
      $rose(RST_B) |-> !SERIAL_EEPROM_CLOCK && !SERIAL_EEPROM_SELECT
      && !SERIAL_EEPROM_DATA_IN) else $error("eeprom idle level");
   chk_tx_idle_level: assert property (
      $rose(RST_B) |-> TX_OUT == {8{~INFRARED_MODE_SELECT_PIN}})
      else $error("serial idle level");
   chk_int_after_reset: assert property (
      $rose(RST_B) |=> TX_INT == 8'h00 && RX_INT == 8'hff)
      else $error("interrupts after reset");
   chk_rx_int_cause: assert property (
      $rose(RX_INT[2]) && $past(RST_B, 2)
      |-> $past(RX_PUSH[2]) || $past(REG_WR) || $past(REG_WR, 2))
      else $error("rx interrupt without cause");
   chk_tx_int_cause: assert property (
      $fell(TX_INT[2])
      |-> $past(TX_PUSH[2]) || $past(REG_WR) || $past(REG_WR, 2))
      else $error("tx interrupt drop without cause");
   chk_stage_ready: assert property (
      $rose(RST_B) |-> RX_PAIR_READY == 8'hff) else $error("stage ready");
endmodule

bind ufl_core ufl_core_props i_ufl_core_props (.SYS_CLK, .RST_B,
   .REG_ADDR, .REG_DWORD, .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID,
   .TX_PUSH, .RX_PUSH, .RX_PAIR_READY, .TX_INT, .RX_INT,
   .INFRARED_MODE_SELECT_PIN, .TX_OUT, .RTS_B, .DTR_B,
   .SERIAL_EEPROM_CLOCK, .SERIAL_EEPROM_SELECT, .SERIAL_EEPROM_DATA_IN);

//--- dv/ufl_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Host software model on the register port
// ----------------------------------------------------------
module ufl_host (
   input wire logic clk,
   output logic [11:0] addr,
   output logic dword,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   initial begin
      {addr, dword, wr, rd, wdata} = 23'h0;
   end
   task automatic put(input logic [11:0] a, input logic [7:0] d,
      input logic dw);
      @(negedge clk);
      {addr, wdata, dword, wr} = {a, d, dw, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic get(input logic [11:0] a, output logic [7:0] d);
      @(negedge clk);
      {addr, dword, rd} = {a, 1'b0, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // Counts move under traffic, so a value is trusted once it repeats.
   task automatic get_stable(input logic [11:0] a, output logic [7:0] d);
      logic [7:0] p;
      get(a, p);
      for (int i = 0; i < 8; i++) begin
         get(a, d);
         if (d === p) break;
         p = d;
      end
   endtask
   task automatic unload(input logic [11:0] w, output logic [7:0] q[$]);
      logic [7:0] d;
      logic [7:0] s;
      q = {};
      put(ufl_pkg::DEV_ID_BYTE_ADDR, 8'h00, 1'b0);
      for (int i = 0; i < 40; i++) begin
         get(w, d);
         get(w, s);
         q.push_back(d);
         q.push_back(s);
         if (s[0] === 1'b0) break;
      end
   endtask
endmodule

//--- dv/ufl_core_tb.sv
`timescale 1ns/10ps
module ufl_core_tb;
   logic clk, rst_b, strap, dw, wr, rd;
   logic [31:0] stb, modem;
   logic [63:0] pc, ps;
   logic [7:0] pv, txs, rts, dtr, wd, rdat, tx_int, rx_int, pr, txo;
   logic [7:0] rts_b, dtr_b, d;
   logic [2:0] ee, eeo;
   logic [11:0] addr;
   logic [7:0] q[$];
   int mismatches = 0;
   int checked = 0;
   ufl_core i_ufl_core (.SYS_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
      .REG_DWORD(dw), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
      .REG_RDATA(rdat), .REG_RVALID(), .TX_PUSH(stb[7:0]),
      .TX_POP(stb[15:8]), .RX_PUSH(stb[23:16]), .RX_POP(stb[31:24]),
      .RX_PAIR_VALID(pv), .RX_PAIR_CHAR(pc), .RX_PAIR_STAT(ps),
      .RX_PAIR_READY(pr), .TX_INT(tx_int), .RX_INT(rx_int),
      .MODEM_IN(modem), .INFRARED_MODE_SELECT_PIN(strap), .TX_SER(txs),
      .TX_OUT(txo), .RTS_REQ(rts), .DTR_REQ(dtr), .RTS_B(rts_b),
      .DTR_B(dtr_b), .EE_CLK_REQ(ee[2]), .EE_SEL_REQ(ee[1]),
      .EE_DIN_REQ(ee[0]), .SERIAL_EEPROM_CLOCK(eeo[2]),
      .SERIAL_EEPROM_SELECT(eeo[1]), .SERIAL_EEPROM_DATA_IN(eeo[0]));
   ufl_host i_ufl_host (.clk(clk), .addr(addr), .dword(dw), .wr(wr),
      .rd(rd), .wdata(wd), .rdata(rdat));
   always #50 clk = ~clk;
   function automatic logic [11:0] ca(input logic [2:0] c,
      input logic [8:0] o);
      return {c, o};
   endfunction
   task automatic check(input string n, input logic [7:0] got,
      input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask
   // Strobe k (tx push, tx pop, rx push, rx pop) held for n edges.
   task automatic pulse(input int k, input int c, input int n);
      @(negedge clk);
      stb[8*k+c] = 1'b1;
      repeat (n) @(negedge clk);
      stb[8*k+c] = 1'b0;
   endtask
   task automatic t_idle();
      check("stage ready", pr, 8'hff);
      i_ufl_host.get(ca(0, 9'h00a), d);
      check("tx level", d, 8'h00);
      i_ufl_host.get(ca(0, 9'h00b), d);
      check("rx level", d, 8'h00);
      i_ufl_host.get(ufl_pkg::GLOBAL_INT_ADDR, d);
      check("global", d, 8'hff);
      i_ufl_host.get(ufl_pkg::CHAN_MAP_FIRST_ADDR, d);
      check("map 1", d, 8'h49);
      i_ufl_host.get(ufl_pkg::CHAN_MAP_MID_ADDR, d);
      check("map 2", d, 8'h92);
      i_ufl_host.get(ufl_pkg::CHAN_MAP_LAST_ADDR, d);
      check("map 3", d, 8'h24);
      i_ufl_host.get(12'h0f0, d);
      check("unmapped", d, 8'h00);
      i_ufl_host.get(ca(0, 9'h006), d);
      check("modem", d, {modem[3:0], 4'h0});
      check("rts", rts_b, ~rts);
      check("dtr", dtr_b, ~dtr);
      check("eeprom", {5'h0, eeo}, {5'h0, ee});
   endtask
   task automatic t_levels();
      pulse(0, 1, 65);
      i_ufl_host.get_stable(ca(1, 9'h00a), d);
      check("tx full", d, 8'h40);
      @(negedge clk);
      stb[9] = 1'b1;
      stb[1] = 1'b1;
      repeat (3) @(negedge clk);
      stb[9] = 1'b0;
      stb[1] = 1'b0;
      pulse(1, 1, 1);
      i_ufl_host.get_stable(ca(1, 9'h00a), d);
      check("tx hold pop", d, 8'h3f);
      pulse(2, 1, 64);
      i_ufl_host.get_stable(ca(1, 9'h00b), d);
      check("rx full", d, 8'h40);
      pulse(3, 1, 65);
      i_ufl_host.get_stable(ca(1, 9'h00b), d);
      check("rx empty", d, 8'h00);
   endtask
   task automatic t_thresh();
      i_ufl_host.put(ca(2, 9'h00b), 8'h02, 1'b0);
      i_ufl_host.put(ca(2, 9'h00a), 8'h03, 1'b0);
      @(negedge clk);
      check("rx int", rx_int, 8'hfb);
      check("tx int", tx_int, 8'h04);
      i_ufl_host.get(ca(2, 9'h00a), d);
      check("level kept", d, 8'h00);
      i_ufl_host.get(ufl_pkg::CHAN_MAP_FIRST_ADDR, d);
      check("map tx", d, 8'h89);
      pulse(0, 2, 2);
      check("tx below", tx_int, 8'h04);
      pulse(0, 2, 1);
      check("tx at", tx_int, 8'h00);
      pulse(2, 2, 1);
      check("rx below", rx_int, 8'hfb);
      pulse(2, 2, 1);
      check("rx at", rx_int, 8'hff);
   endtask
   task automatic t_unload();
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         pv[4] = 1'b1;
         pc[39:32] = 8'h10 + 8'(i);
         ps[39:32] = {4'(i), 4'h1};
      end
      @(negedge clk);
      pv[4] = 1'b0;
      check("stage full", pr, 8'hef);
      i_ufl_host.unload(ca(4, 9'h180), q);
      check("count", 8'(q.size()), 8'h12);
      for (int i = 0; i < 8; i++) begin
         check("char", q[2*i], 8'h10 + 8'(i));
         check("stat", q[2*i+1], {4'(i), 4'h1});
      end
      check("empty", q[17], 8'h00);
      @(negedge clk);
      {pv[4], pc[39:32], ps[39:32]} = {1'b1, 8'hab, 8'h31};
      @(negedge clk);
      pv[4] = 1'b0;
      i_ufl_host.put(ufl_pkg::DEV_ID_BYTE_ADDR, 8'h00, 1'b0);
      i_ufl_host.get(ca(4, 9'h180), d);
      check("first", d, 8'hab);
      i_ufl_host.get(ufl_pkg::DEV_ID_BYTE_ADDR, d);
      check("id", d, ufl_pkg::DEVICE_ID_VALUE);
      i_ufl_host.put(ufl_pkg::DEV_ID_DWORD_ADDR, 8'h00, 1'b1);
      i_ufl_host.get(ca(4, 9'h180), d);
      check("rearmed", d, 8'hab);
      i_ufl_host.get(ca(4, 9'h180), d);
      check("status", d, 8'h31);
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      wrap_up();
   end
   initial begin
      {clk, rst_b, strap, stb, pv, pc, ps} = 171'h0;
      {modem, txs, rts, dtr, ee} = {32'h0000000a, 8'h96, 8'h3c, 8'h0f, 3'h5};
      repeat (2) @(negedge clk);
      check("tx idle", txo, 8'hff);
      strap = 1'b1;
      #1;
      check("tx idle ir", txo, 8'h00);
      check("dtr idle", dtr_b, 8'hff);
      strap = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      t_idle();
      t_levels();
      t_thresh();
      t_unload();
      wrap_up();
   end
endmodule
